// ==== logic/cmd_filter_pkg.sv ====
// Shared constants and carriers for the bridge command front end
package cmd_filter_pkg;
    // Bus command codes
    localparam logic [3:0] CMD_INTACK = 4'h0;
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_RSV4 = 4'h4;
    localparam logic [3:0] CMD_RSV5 = 4'h5;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_RSV8 = 4'h8;
    localparam logic [3:0] CMD_RSV9 = 4'h9;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [3:0] CMD_MEM_RDM = 4'hC;
    localparam logic [3:0] CMD_DAC = 4'hD;
    localparam logic [3:0] CMD_MEM_RDL = 4'hE;
    localparam logic [3:0] CMD_MEM_WRI = 4'hF;
    // Buffer sizing: bytes per buffer and entry counts
    localparam int BUF_BYTES = 128;
    localparam int BUF_WORDS = BUF_BYTES / 4;
    localparam int WR_BUFS = 2;
    localparam int RD_BUFS = 4;
    localparam int ADDR_W = 32;
    localparam logic [1:0] LINEAR_MODE = 2'h0;
    localparam logic [1:0] CFG_TYPE1 = 2'h1;
    localparam logic BUS_PRI = 1'b0;
    localparam logic BUS_SEC = 1'b1;

    // Address phase as seen on one bus
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [3:0] cmd;
    } addr_phase_t;

    // Request to initiate a transaction as master
    typedef struct packed {
        logic valid;
        logic bus;
        logic [ADDR_W-1:0] addr;
        logic [3:0] cmd;
    } master_req_t;

    // One buffered entry: address, data, command, byte enables
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] cmd;
        logic [3:0] byte_en;
    } buf_entry_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FIRST = 2'b01,
        ST_BURST = 2'b11,
        ST_DISC = 2'b10
    } xfer_state_t;
endpackage

// ==== logic/cmd_filter.sv ====
// Command claim and master filter with buffer storage for one bridge
`timescale 1ns/1ns
module cmd_filter (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Address phases from primary and secondary buses
    input cmd_filter_pkg::addr_phase_t PRI_ADDR,
    input cmd_filter_pkg::addr_phase_t SEC_ADDR,
    // Data phase of the claimed transaction
    input wire logic DATA_XFER,
    input wire logic LAST_DATA,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] BYTE_EN,
    // Requests to act as master
    input cmd_filter_pkg::master_req_t MST_REQ,
    // Buffer reads
    input wire logic [2:0] RD_BUF_SEL,
    input wire logic [4:0] RD_IDX,
    // Outputs
    output logic PRI_CLAIM,
    output logic SEC_CLAIM,
    output cmd_filter_pkg::master_req_t MST_OUT,
    output logic MST_REJECT,
    output logic DISCONNECT,
    output cmd_filter_pkg::buf_entry_t RD_ENTRY
);
    import cmd_filter_pkg::*;

    // Claim decision for one address phase
    function automatic logic target_ok(input logic bus, input logic [3:0] cmd,
                                       input logic [1:0] low);
        logic ok;
        ok = 1'b0;
        case (cmd)
            CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RDM, CMD_DAC,
            CMD_MEM_RDL, CMD_MEM_WRI: ok = 1'b1;
            CMD_CFG_RD: ok = (bus == BUS_PRI);
            CMD_CFG_WR: ok = (bus == BUS_PRI) || (low == CFG_TYPE1);
            default: ok = 1'b0; // Interrupt ack, special, reserved
        endcase
        return ok;
    endfunction

    // Master permission; special cycles needed elsewhere arrive as Type 1 config writes
    function automatic logic master_ok(input logic bus, input logic [3:0] cmd,
                                       input logic [1:0] low);
        logic ok;
        ok = 1'b0;
        case (cmd)
            CMD_SPECIAL: ok = 1'b1;
            CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RDM, CMD_DAC,
            CMD_MEM_RDL, CMD_MEM_WRI: ok = 1'b1;
            CMD_CFG_RD: ok = (bus == BUS_SEC);
            CMD_CFG_WR: ok = (bus == BUS_SEC) || (low == CFG_TYPE1);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    logic pri_claim_r, pri_claim_nxt;
    logic sec_claim_r, sec_claim_nxt;
    master_req_t mst_r, mst_nxt;
    logic mst_rej_r, mst_rej_nxt;
    logic disc_r, disc_nxt;
    xfer_state_t state_r, state_nxt;
    logic buf_sel_r, buf_sel_nxt;
    logic [4:0] wr_ptr_r, wr_ptr_nxt;
    logic [ADDR_W-1:0] cur_addr_r, cur_addr_nxt;
    logic [3:0] cur_cmd_r, cur_cmd_nxt;
    logic [1:0] rd_ptr_r, rd_ptr_nxt;
    buf_entry_t rd_entry_r, rd_entry_nxt;
    logic is_read;
    logic is_write;

    // Six 32-word buffers: 0..1 write, 2..5 read
    buf_entry_t mem [WR_BUFS+RD_BUFS][BUF_WORDS];

    // Claim stage: the full address and command are taken in one phase
    always_comb begin
        pri_claim_nxt = PRI_ADDR.valid &&
            target_ok(BUS_PRI, PRI_ADDR.cmd, PRI_ADDR.addr[1:0]);
        sec_claim_nxt = SEC_ADDR.valid && !PRI_ADDR.valid &&
            target_ok(BUS_SEC, SEC_ADDR.cmd, SEC_ADDR.addr[1:0]);
        mst_nxt = '0;
        mst_rej_nxt = 1'b0;
        if (MST_REQ.valid) begin
            if (master_ok(MST_REQ.bus, MST_REQ.cmd, MST_REQ.addr[1:0])) begin
                mst_nxt = MST_REQ;
            end else begin
                mst_rej_nxt = 1'b1;
            end
        end
    end

    // Target and master filter checks
    no_bad_claim_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        PRI_ADDR.valid && (PRI_ADDR.cmd == CMD_INTACK || PRI_ADDR.cmd == CMD_SPECIAL)
        |=> !PRI_CLAIM) else $error("Primary claimed intack or special cycle");

    reserved_ignored_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        SEC_ADDR.valid && (SEC_ADDR.cmd[3:1] == 3'h2 || SEC_ADDR.cmd[3:1] == 3'h4)
        |=> !SEC_CLAIM) else $error("Secondary claimed a reserved code");

    cfg_rd_sec_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        SEC_ADDR.valid && SEC_ADDR.cmd == CMD_CFG_RD |=> !SEC_CLAIM)
        else $error("Config read claimed on secondary");

    cfg_type0_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        SEC_ADDR.valid && !PRI_ADDR.valid && SEC_ADDR.cmd == CMD_CFG_WR &&
        SEC_ADDR.addr[1:0] == 2'h0 |=> !SEC_CLAIM) else $error("Type 0 claimed on secondary");

    mem_claim_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        PRI_ADDR.valid && PRI_ADDR.cmd == CMD_MEM_WR |=> PRI_CLAIM)
        else $error("Memory write not claimed on primary");

    addr_capture_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        state_r == ST_IDLE && pri_claim_nxt |=> cur_addr_r == $past(PRI_ADDR.addr) &&
        cur_cmd_r == $past(PRI_ADDR.cmd)) else $error("Address phase not captured whole");

    special_master_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        MST_REQ.valid && MST_REQ.cmd == CMD_SPECIAL |=> MST_OUT.valid && !MST_REJECT)
        else $error("Special cycle master request refused");

    intack_master_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        MST_REQ.valid && MST_REQ.cmd == CMD_INTACK |=> MST_REJECT && !MST_OUT.valid)
        else $error("Interrupt acknowledge accepted as master");

    master_filter_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        MST_OUT.valid |-> MST_OUT.cmd != CMD_INTACK && MST_OUT.cmd[3:1] != 3'h2 &&
        MST_OUT.cmd[3:1] != 3'h4) else $error("Forbidden command issued as master");

    cfg_read_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        MST_REQ.valid && MST_REQ.cmd == CMD_CFG_RD && MST_REQ.bus == BUS_PRI
        |=> MST_REJECT) else $error("Config read initiated on primary");

    type1_master_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        MST_OUT.valid && MST_OUT.bus == BUS_PRI && MST_OUT.cmd == CMD_CFG_WR
        |-> MST_OUT.addr[1:0] == CFG_TYPE1) else $error("Type 0 config write issued on primary");

    assign is_read = (cur_cmd_r == CMD_IO_RD) || (cur_cmd_r == CMD_MEM_RD) ||
        (cur_cmd_r == CMD_CFG_RD) || (cur_cmd_r == CMD_MEM_RDM) ||
        (cur_cmd_r == CMD_MEM_RDL);
    assign is_write = DATA_XFER && (state_r == ST_FIRST || state_r == ST_BURST);

    // Data stage: linear bursts continue, others stop after one transfer
    always_comb begin
        state_nxt = state_r;
        disc_nxt = 1'b0;
        buf_sel_nxt = buf_sel_r;
        wr_ptr_nxt = wr_ptr_r;
        cur_addr_nxt = cur_addr_r;
        cur_cmd_nxt = cur_cmd_r;
        rd_ptr_nxt = rd_ptr_r;
        case (state_r)
            ST_IDLE: begin
                if (pri_claim_r || sec_claim_r) begin
                    state_nxt = ST_FIRST;
                    wr_ptr_nxt = '0;
                end
            end
            ST_FIRST: begin
                if (DATA_XFER) begin
                    wr_ptr_nxt = wr_ptr_r + 5'h1;
                    if (LAST_DATA) begin
                        state_nxt = ST_IDLE;
                    end else if (cur_addr_r[1:0] != LINEAR_MODE) begin
                        state_nxt = ST_DISC;
                        disc_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_BURST;
                    end
                end
            end
            ST_BURST: begin
                if (DATA_XFER) begin
                    wr_ptr_nxt = wr_ptr_r + 5'h1;
                    if (LAST_DATA) begin
                        state_nxt = ST_IDLE;
                    end else if (wr_ptr_r == 5'h1F) begin
                        // Buffer full: stop the initiator rather than overrun
                        state_nxt = ST_DISC;
                        disc_nxt = 1'b1;
                    end
                end
            end
            ST_DISC: begin
                state_nxt = ST_IDLE;
                if (is_read) begin
                    rd_ptr_nxt = rd_ptr_r + 2'h1;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (state_r != ST_DISC && state_nxt == ST_IDLE && state_r != ST_IDLE && is_read) begin
            rd_ptr_nxt = rd_ptr_r + 2'h1;
        end
        if (state_r == ST_IDLE && (pri_claim_r || sec_claim_r)) begin
            // Downstream uses buffer 0, upstream buffer 1
            buf_sel_nxt = sec_claim_r;
        end
        if (state_r == ST_IDLE && (pri_claim_nxt || sec_claim_nxt)) begin
            // Only a claimed phase is kept: a released bus carries junk
            cur_addr_nxt = pri_claim_nxt ? PRI_ADDR.addr : SEC_ADDR.addr;
            cur_cmd_nxt = pri_claim_nxt ? PRI_ADDR.cmd : SEC_ADDR.cmd;
        end
        rd_entry_nxt = mem[RD_BUF_SEL][RD_IDX];
    end

    // Burst and buffer checks
    unaligned_disc_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        state_r == ST_FIRST && DATA_XFER && !LAST_DATA && cur_addr_r[1:0] != 2'h0
        |=> DISCONNECT ##1 !DISCONNECT) else $error("Unaligned burst not disconnected");

    linear_burst_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        state_r == ST_FIRST && DATA_XFER && !LAST_DATA && cur_addr_r[1:0] == 2'h0
        |=> !DISCONNECT && state_r == ST_BURST) else $error("Linear burst cut short");

    disc_pulse_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        DISCONNECT |=> !DISCONNECT) else $error("Disconnect held past one cycle");

    buffer_full_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        state_r == ST_BURST && DATA_XFER && !LAST_DATA && wr_ptr_r == 5'h1F
        |=> DISCONNECT) else $error("Full buffer not disconnected");

    word_order_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        state_r == ST_BURST && DATA_XFER |=> wr_ptr_r == $past(wr_ptr_r) + 5'h1)
        else $error("Buffer entries not filled in order");

    read_rotate_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        state_r == ST_DISC && is_read |=> rd_ptr_r == $past(rd_ptr_r) + 2'h1)
        else $error("Read buffer not advanced");

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            pri_claim_r <= 1'b0;
            sec_claim_r <= 1'b0;
            mst_r <= '0;
            mst_rej_r <= 1'b0;
            disc_r <= 1'b0;
            state_r <= ST_IDLE;
            buf_sel_r <= 1'b0;
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            rd_entry_r <= '0;
        end else begin
            pri_claim_r <= pri_claim_nxt;
            sec_claim_r <= sec_claim_nxt;
            mst_r <= mst_nxt;
            mst_rej_r <= mst_rej_nxt;
            disc_r <= disc_nxt;
            state_r <= state_nxt;
            buf_sel_r <= buf_sel_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            rd_entry_r <= rd_entry_nxt;
        end
    end

    // Latched address phase of the claimed transaction
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            cur_addr_r <= '0;
            cur_cmd_r <= '0;
        end else begin
            cur_addr_r <= cur_addr_nxt;
            cur_cmd_r <= cur_cmd_nxt;
        end
    end

    // Storage has no reset; contents are only meaningful once written
    always_ff @(posedge MCLK) begin
        if (is_write) begin
            if (is_read) begin
                mem[3'(WR_BUFS) + 3'(rd_ptr_r)][wr_ptr_r] <=
                    '{addr: cur_addr_r, data: WDATA, cmd: cur_cmd_r, byte_en: BYTE_EN};
            end else begin
                mem[3'(buf_sel_r)][wr_ptr_r] <=
                    '{addr: cur_addr_r, data: WDATA, cmd: cur_cmd_r, byte_en: BYTE_EN};
            end
        end
    end

    assign PRI_CLAIM = pri_claim_r;
    assign SEC_CLAIM = sec_claim_r;
    assign MST_OUT = mst_r;
    assign MST_REJECT = mst_rej_r;
    assign DISCONNECT = disc_r;
    assign RD_ENTRY = rd_entry_r;
endmodule

// ==== sim/pci_initiator_model.sv ====
// Behavioural initiator agent that drives address and data phases into the bridge
`timescale 1ns/1ns
module pci_initiator_model (
    // Clock
    input wire logic mclk,
    // Address phases on both buses
    output cmd_filter_pkg::addr_phase_t pri_addr,
    output cmd_filter_pkg::addr_phase_t sec_addr,
    // Data phase
    output logic data_xfer,
    output logic last_data,
    output logic [31:0] wdata,
    output logic [3:0] byte_en
);
    import cmd_filter_pkg::*;

    initial begin
        pri_addr = '0;
        sec_addr = '0;
        data_xfer = 1'b0;
        last_data = 1'b0;
        wdata = 32'h0;
        byte_en = 4'h0;
    end

    task addr_phase(input logic bus, input logic [3:0] cmd, input logic [31:0] a);
        @(posedge mclk);
        #2;
        if (bus == BUS_PRI) pri_addr = '{1'b1, a, cmd};
        else sec_addr = '{1'b1, a, cmd};
        @(posedge mclk);
        #2;
        // Released lines show the inverse so a late sample never matches by luck
        if (bus == BUS_PRI) pri_addr = '{1'b0, ~a, ~cmd};
        else sec_addr = '{1'b0, ~a, ~cmd};
    endtask

    task data_word(input logic last, input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        #2;
        data_xfer = 1'b1;
        last_data = last;
        wdata = d;
        byte_en = be;
        @(posedge mclk);
        #2;
        data_xfer = 1'b0;
        last_data = 1'b0;
        wdata = ~d;
        byte_en = ~be;
    endtask
endmodule

// ==== sim/cmd_filter_tb.sv ====
// Self-checking bench for the bridge command front end
`timescale 1ns/1ns
module cmd_filter_tb;
    import cmd_filter_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    addr_phase_t pri_addr;
    addr_phase_t sec_addr;
    logic data_xfer;
    logic last_data;
    logic [31:0] wdata;
    logic [3:0] byte_en;
    master_req_t mst_req = '0;
    logic [2:0] rd_sel = 3'h0;
    logic [4:0] rd_idx = 5'h00;
    logic pri_claim;
    logic sec_claim;
    logic mst_reject;
    logic disconnect;
    master_req_t mst_out;
    buf_entry_t rd_entry;
    logic [39:0] notes[$];
    logic [31:0] seed = 32'h0000005A;
    logic [31:0] a;
    logic [31:0] a0;
    logic [31:0] d0;
    logic [31:0] dl;
    logic [3:0] b0;
    logic [3:0] bl;
    logic [3:0] cmd;
    logic [1:0] low;
    logic bus;
    int failures = 0;
    int checked = 0;

    always #25 mclk = ~mclk;

    pci_initiator_model pci_initiator_model_inst (.mclk(mclk), .pri_addr(pri_addr),
        .sec_addr(sec_addr), .data_xfer(data_xfer), .last_data(last_data),
        .wdata(wdata), .byte_en(byte_en));

    cmd_filter cmd_filter_inst (.MCLK(mclk), .RESETN(resetn), .PRI_ADDR(pri_addr),
        .SEC_ADDR(sec_addr), .DATA_XFER(data_xfer), .LAST_DATA(last_data),
        .WDATA(wdata), .BYTE_EN(byte_en), .MST_REQ(mst_req), .RD_BUF_SEL(rd_sel),
        .RD_IDX(rd_idx), .PRI_CLAIM(pri_claim), .SEC_CLAIM(sec_claim),
        .MST_OUT(mst_out), .MST_REJECT(mst_reject), .DISCONNECT(disconnect),
        .RD_ENTRY(rd_entry));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic claim_ok(input logic b, input logic [3:0] c, input logic [1:0] l);
        case (c)
            CMD_INTACK, CMD_SPECIAL, CMD_RSV4, CMD_RSV5, CMD_RSV8, CMD_RSV9: return 1'b0;
            CMD_CFG_RD: return b == BUS_PRI;
            CMD_CFG_WR: return b == BUS_PRI || l == CFG_TYPE1;
            default: return 1'b1;
        endcase
    endfunction

    function automatic logic mst_ok(input logic b, input logic [3:0] c, input logic [1:0] l);
        case (c)
            CMD_INTACK, CMD_RSV4, CMD_RSV5, CMD_RSV8, CMD_RSV9: return 1'b0;
            CMD_CFG_RD: return b == BUS_SEC;
            CMD_CFG_WR: return b == BUS_SEC || l == CFG_TYPE1;
            default: return 1'b1;
        endcase
    endfunction

    task fail(input string m);
        failures++;
        $display("mismatch %0t %s", $time, m);
    endtask

    task check_note(input logic [39:0] obs);
        checked++;
        if (notes.size() == 0 || notes[0] !== obs) fail("unexpected output event");
        if (notes.size() != 0) void'(notes.pop_front());
    endtask

    task print_verdict();
        checked++;
        if (notes.size() != 0) fail("expected output event missing");
        if (failures == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task rd_look(input logic [4:0] i);
        @(posedge mclk);
        #2 rd_idx = i;
        repeat (2) @(posedge mclk);
        #2;
    endtask

    // Outputs are registered, so the falling edge sees them settled
    always @(negedge mclk) if (resetn === 1'b1) begin
        if (pri_claim !== 1'b0) check_note({3'h1, 37'h0});
        if (sec_claim !== 1'b0) check_note({3'h2, 37'h0});
        if (mst_out.valid !== 1'b0) begin
            check_note({3'h3, mst_out.bus, mst_out.cmd, mst_out.addr});
        end
        if (mst_reject !== 1'b0) check_note({3'h4, 37'h0});
        if (disconnect !== 1'b0) check_note({3'h5, 37'h0});
    end

    initial begin
        #(20000 * 50);
        fail("watchdog expired");
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge mclk);
        #2 resetn = 1'b1;
        seed = xs(seed);
        a0 = {seed[31:2], LINEAR_MODE};
        notes.push_back({3'h1, 37'h0});
        pci_initiator_model_inst.addr_phase(BUS_PRI, CMD_MEM_WR, a0);
        @(posedge mclk);
        for (int i = 0; i < 32; i++) begin
            seed = xs(seed);
            if (i == 0) d0 = seed;
            if (i == 0) b0 = seed[7:4];
            dl = seed;
            bl = seed[7:4];
            // A full buffer ends even an aligned burst
            if (i == 31) notes.push_back({3'h5, 37'h0});
            pci_initiator_model_inst.data_word(1'b0, seed, seed[7:4]);
        end
        rd_look(5'h00);
        checked++;
        if (rd_entry !== {a0, d0, CMD_MEM_WR, b0}) fail("first buffer entry");
        rd_look(5'h1F);
        checked++;
        if (rd_entry[39:0] !== {dl, CMD_MEM_WR, bl}) fail("last buffer entry");
        for (int k = 0; k < 64; k++) begin
            bus = k[5];
            cmd = k[4:1];
            low = {1'b0, k[0]};
            seed = xs(seed);
            a = {seed[31:2], low};
            if (claim_ok(bus, cmd, low)) begin
                notes.push_back({bus ? 3'h2 : 3'h1, 37'h0});
                if (low != LINEAR_MODE) notes.push_back({3'h5, 37'h0});
            end
            pci_initiator_model_inst.addr_phase(bus, cmd, a);
            @(posedge mclk);
            if (claim_ok(bus, cmd, low)) begin
                pci_initiator_model_inst.data_word(low == LINEAR_MODE, a, a[7:4]);
            end
            repeat (3) @(posedge mclk);
        end
        for (int k = 0; k < 64; k++) begin
            bus = k[5];
            cmd = k[4:1];
            low = {1'b0, k[0]};
            seed = xs(seed);
            a = {seed[31:2], low};
            if (mst_ok(bus, cmd, low)) begin
                notes.push_back({3'h3, bus, cmd, a});
            end else begin
                notes.push_back({3'h4, 37'h0});
            end
            @(posedge mclk);
            #2 mst_req = '{1'b1, bus, a, cmd};
            @(posedge mclk);
            #2 mst_req = '{1'b0, ~bus, ~a, ~cmd};
        end
        repeat (4) @(posedge mclk);
        print_verdict();
    end
endmodule
